// ==== ist_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module ist_ctrl #(
  parameter logic [15:0] BIT_DIV = ist_pkg::BIT_DIV_DEF
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_swrst,
  input wire logic [1:0] i_serial_mode_select,
  input wire logic i_synchronous_select,
  input wire logic i_master_select,
  input wire logic i_multi_master_enable,
  input wire logic [9:0] i_own_address_reg,
  input wire logic i_own_addr_ten_bit_sel,
  input wire logic i_own_address_enable,
  input wire logic i_general_call_enable,
  input wire logic [9:0] i_target_address_reg,
  input wire logic i_target_addr_ten_bit_sel,
  input wire logic [1:0] i_auto_stop_select,
  input wire logic [7:0] i_byte_threshold,
  input wire logic i_dir_wr,
  input wire logic i_dir_val,
  input wire logic i_start_request_set,
  input wire logic i_stop_request_set,
  input wire logic i_send_nack_set,
  input wire logic i_tx_wr,
  input wire logic [7:0] i_tx_data,
  input wire logic i_rx_rd,
  input wire logic [4:0] i_flag_clr,
  output logic [7:0] o_receive_buffer,
  output logic o_receive_flag,
  output logic o_transmit_flag,
  output logic o_start_match_flag,
  output logic o_stop_detected_flag,
  output logic o_nack_flag,
  output logic o_transmit_direction_bit,
  output logic o_start_request,
  output logic o_stop_request,
  output logic o_send_nack_request,
  output logic o_bus_busy,
  output logic o_master_active,
  output logic o_scl_stretch
);

  localparam logic [15:0] HALF_M1 = (BIT_DIV >> 1) - 16'h0001;

  typedef struct packed {
    ist_pkg::ist_state_t st;
    logic [1:0] sub;
    logic [15:0] tmr;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] pend;
    logic pend_v;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic txb_v;
    logic rxf;
    logic txf;
    logic sttf;
    logic stpf;
    logic nackf;
    logic tr;
    logic start_req;
    logic stop_req;
    logic nack_req;
    logic master;
    logic [1:0] addr_ph;
    logic abyte;
    logic addressed;
    logic ten_ok;
    logic nacked;
    logic sda_drv;
    logic hold_low;
    logic busy;
    logic [7:0] bcnt;
  } ist_ctl_t;

  localparam ist_ctl_t CTL_RST = '{st: ist_pkg::ST_IDLE, default: '0};

  ist_ctl_t r;
  ist_ctl_t n;

  logic scl;
  logic sda;
  logic sc_rise;
  logic sc_fall;
  logic sc_start;
  logic sc_stop;
  logic gen_low;
  logic en;
  logic slave_ok;
  logic auto_hit;
  logic stop_go;
  logic txrole;
  logic half_done;
  logic [7:0] rx_byte;
  logic [7:0] adr_byte;

  // ---------------------------------------------------------------
  // Line sampling and bit clock
  // ---------------------------------------------------------------
  ist_pin_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl(scl),
    .o_sda(sda),
    .o_scl_rise(sc_rise),
    .o_scl_fall(sc_fall),
    .o_start(sc_start),
    .o_stop(sc_stop)
  );

  ist_scl_gen #(
    .BIT_DIV(BIT_DIV)
  ) u_gen (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_run(r.master && (r.st == ist_pkg::ST_XFER)),
    .i_scl(scl),
    .o_scl_low(gen_low)
  );

  // ---------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------
  // mode gating
  assign en = !i_swrst && i_synchronous_select
    && (i_serial_mode_select == ist_pkg::MODE_I2C);
  assign slave_ok = i_own_address_enable
    && (!i_master_select || i_multi_master_enable);
  assign auto_hit = (i_auto_stop_select == ist_pkg::ASTP_BYTECNT)
    && (i_byte_threshold != 8'h00) && (r.bcnt == i_byte_threshold);
  assign stop_go = r.stop_req | auto_hit;
  assign txrole = r.master && ((r.addr_ph != ist_pkg::PH_DATA) || r.tr);
  assign half_done = (r.tmr == HALF_M1);
  assign rx_byte = {r.sh[6:0], sda};
  assign adr_byte = i_target_addr_ten_bit_sel ?
    {ist_pkg::TEN_HDR, i_target_address_reg[9:8],
     r.addr_ph == ist_pkg::PH_REREAD} :
    {i_target_address_reg[6:0], ~r.tr};

  always_comb
  begin
    n = r;
    if (i_dir_wr)
      n.tr = i_dir_val;
    if (i_start_request_set)
      n.start_req = 1'b1;
    if (i_stop_request_set)
      n.stop_req = 1'b1;
    if (i_send_nack_set)
      n.nack_req = 1'b1;
    if (i_flag_clr[ist_pkg::FCLR_RX])
      n.rxf = 1'b0;
    if (i_flag_clr[ist_pkg::FCLR_TX])
      n.txf = 1'b0;
    if (i_flag_clr[ist_pkg::FCLR_STT])
      n.sttf = 1'b0;
    if (i_flag_clr[ist_pkg::FCLR_STP])
      n.stpf = 1'b0;
    if (i_flag_clr[ist_pkg::FCLR_NACK])
      n.nackf = 1'b0;
    if (i_tx_wr)
    begin
      n.txbuf = i_tx_data;
      n.txb_v = 1'b1;
      n.txf = 1'b0;
    end
    if (i_rx_rd)
    begin
      n.rxf = 1'b0;
      if (r.pend_v)
      begin
        n.rxbuf = r.pend;
        n.rxf = 1'b1;
        n.pend_v = 1'b0;
      end
    end
    if (sc_start)
      n.busy = 1'b1;
    if (sc_stop)
      n.busy = 1'b0;

    case (r.st)
      ist_pkg::ST_IDLE:
      begin
        if (i_master_select && r.start_req && !r.busy)
        begin
          n.st = ist_pkg::ST_MSTA;
          n.sub = ist_pkg::SUB_0;
          n.master = 1'b1;
          n.addr_ph = ist_pkg::PH_FIRST;
          n.nacked = 1'b0;
          n.bcnt = 8'h00;
        end
      end
      ist_pkg::ST_MSTA:
      begin
        n.sda_drv = (r.sub == ist_pkg::SUB_2);
        if (r.sub != ist_pkg::SUB_0)
          n.hold_low = 1'b0;
        if ((r.sub != ist_pkg::SUB_1) || scl)
        begin
          n.tmr = r.tmr + 16'h0001;
          if (half_done)
          begin
            n.tmr = ist_pkg::TMR_RST;
            n.sub = r.sub + 2'h1;
            if (r.sub == ist_pkg::SUB_2)
            begin
              if (r.tr && (r.addr_ph == ist_pkg::PH_FIRST))
                n.txf = 1'b1;
              n.sh = adr_byte;
              n.bitcnt = 4'h0;
              n.st = ist_pkg::ST_XFER;
            end
          end
        end
      end
      ist_pkg::ST_MSTP:
      begin
        n.sda_drv = (r.sub != ist_pkg::SUB_2);
        n.hold_low = (r.sub == ist_pkg::SUB_0);
        if ((r.sub == ist_pkg::SUB_0) || (r.sub == ist_pkg::SUB_1 && scl))
        begin
          n.tmr = r.tmr + 16'h0001;
          if (half_done)
          begin
            n.tmr = ist_pkg::TMR_RST;
            n.sub = r.sub + 2'h1;
          end
        end
        if ((r.sub == ist_pkg::SUB_2) && sc_stop)
        begin
          n.stpf = 1'b1;
          n.stop_req = 1'b0;
          n.master = 1'b0;
          n.st = ist_pkg::ST_IDLE;
        end
      end
      ist_pkg::ST_XFER:
      begin
        if (sc_fall)
        begin
          if (r.bitcnt < ist_pkg::BIT_ACK)
          begin
            n.sda_drv = txrole & ~r.sh[7];
            if (r.master && !txrole && r.rxf && !stop_go
                && (r.bitcnt == ist_pkg::BIT_LAST))
            begin
              n.st = ist_pkg::ST_HOLD;
              n.sub = ist_pkg::SUB_0;
              n.hold_low = 1'b1;
            end
          end
          else if (r.bitcnt == ist_pkg::BIT_ACK)
          begin
            if (txrole)
              n.sda_drv = 1'b0;
            else if (r.master)
              n.sda_drv = !(stop_go || r.start_req);
            else if (r.abyte)
              n.sda_drv = 1'b1;
            else if (r.nack_req)
            begin
              n.sda_drv = 1'b0;
              n.nack_req = 1'b0;
            end
            else if (r.pend_v)
            begin
              n.st = ist_pkg::ST_HOLD;
              n.sub = ist_pkg::SUB_0;
              n.hold_low = 1'b1;
            end
            else
              n.sda_drv = 1'b1;
          end
          else
          begin
            n.sda_drv = 1'b0;
            n.bitcnt = 4'h0;
            if (r.master)
            begin
              n.st = ist_pkg::ST_HOLD;
              n.sub = ist_pkg::SUB_0;
              n.hold_low = 1'b1;
            end
            else if (!((r.addressed && !r.tr)
                       || (r.addr_ph == ist_pkg::PH_SECOND)))
              n.st = ist_pkg::ST_IDLE;
          end
        end
        if (sc_rise && (r.bitcnt < ist_pkg::BIT_ACK))
        begin
          n.sh = rx_byte;
          n.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == ist_pkg::BIT_LAST)
          begin
            n.abyte = (r.addr_ph != ist_pkg::PH_DATA);
            if (r.master)
            begin
              if ((r.addr_ph == ist_pkg::PH_REREAD)
                  || (r.addr_ph == ist_pkg::PH_FIRST
                      && !i_target_addr_ten_bit_sel)
                  || (r.addr_ph == ist_pkg::PH_SECOND && r.tr))
                n.start_req = 1'b0;
              if (r.addr_ph == ist_pkg::PH_DATA)
                n.bcnt = r.bcnt + 8'h01;
            end
            else if (r.addr_ph == ist_pkg::PH_FIRST)
            begin
              n.st = ist_pkg::ST_IDLE;
              if (slave_ok && !i_own_addr_ten_bit_sel)
              begin
                if ((rx_byte[7:1] == i_own_address_reg[6:0])
                    || (i_general_call_enable
                        && rx_byte == ist_pkg::GC_ADDR))
                begin
                  n.st = ist_pkg::ST_XFER;
                  n.addressed = 1'b1;
                  n.tr = rx_byte[0];
                  n.sttf = 1'b1;
                  n.addr_ph = ist_pkg::PH_DATA;
                end
              end
              else if (slave_ok && (rx_byte[7:3] == ist_pkg::TEN_HDR)
                       && (rx_byte[2:1] == i_own_address_reg[9:8]))
              begin
                n.st = ist_pkg::ST_XFER;
                if (!rx_byte[0])
                  n.addr_ph = ist_pkg::PH_SECOND;
                else if (r.ten_ok)
                begin
                  n.addressed = 1'b1;
                  n.tr = 1'b1;
                  n.sttf = 1'b1;
                  n.addr_ph = ist_pkg::PH_DATA;
                end
                else
                  n.st = ist_pkg::ST_IDLE;
              end
            end
            else if (r.addr_ph == ist_pkg::PH_SECOND)
            begin
              if (rx_byte == i_own_address_reg[7:0])
              begin
                n.ten_ok = 1'b1;
                n.addressed = 1'b1;
                n.tr = 1'b0;
                n.sttf = 1'b1;
                n.addr_ph = ist_pkg::PH_DATA;
              end
              else
                n.st = ist_pkg::ST_IDLE;
            end
            else
              n.bcnt = r.bcnt + 8'h01;
            if (!txrole && (r.addr_ph == ist_pkg::PH_DATA)
                && (r.master || (r.addressed && !r.tr)))
            begin
              if (!n.rxf)
              begin
                n.rxbuf = rx_byte;
                n.rxf = 1'b1;
              end
              else
              begin
                n.pend = rx_byte;
                n.pend_v = 1'b1;
              end
            end
          end
        end
        else if (sc_rise && (r.bitcnt == ist_pkg::BIT_ACK))
        begin
          n.bitcnt = ist_pkg::BIT_POST;
          if (txrole && sda)
          begin
            n.nackf = 1'b1;
            n.nacked = 1'b1;
            n.txb_v = 1'b0;
            n.start_req = 1'b0;
            n.stop_req = 1'b0;
          end
        end
      end
      ist_pkg::ST_HOLD:
      begin
        if (r.sub == ist_pkg::SUB_1)
        begin
          n.hold_low = 1'b0;
          n.st = ist_pkg::ST_XFER;
        end
        else if (!r.master)
        begin
          if (r.nack_req)
          begin
            if (r.pend_v)
              n.rxbuf = r.pend;
            n.rxf = 1'b1;
            n.pend_v = 1'b0;
            n.nack_req = 1'b0;
            n.sda_drv = 1'b0;
            n.sub = ist_pkg::SUB_1;
          end
          else if (!r.pend_v)
          begin
            n.sda_drv = 1'b1;
            n.sub = ist_pkg::SUB_1;
          end
        end
        else if (r.bitcnt == ist_pkg::BIT_LAST)
        begin
          if (!r.rxf || stop_go)
            n.sub = ist_pkg::SUB_1;
        end
        else if (!r.nacked && (r.addr_ph == ist_pkg::PH_FIRST)
                 && i_target_addr_ten_bit_sel)
        begin
          n.sh = i_target_address_reg[7:0];
          n.sda_drv = ~i_target_address_reg[7];
          n.addr_ph = ist_pkg::PH_SECOND;
          n.sub = ist_pkg::SUB_1;
        end
        else if (!r.nacked && (r.addr_ph == ist_pkg::PH_SECOND) && !r.tr)
        begin
          n.st = ist_pkg::ST_MSTA;
          n.sub = ist_pkg::SUB_0;
          n.addr_ph = ist_pkg::PH_REREAD;
        end
        else if (stop_go)
        begin
          n.st = ist_pkg::ST_MSTP;
          n.sub = ist_pkg::SUB_0;
        end
        else if (r.start_req)
        begin
          n.st = ist_pkg::ST_MSTA;
          n.sub = ist_pkg::SUB_0;
          n.addr_ph = ist_pkg::PH_FIRST;
          n.nacked = 1'b0;
          n.bcnt = 8'h00;
        end
        else if (r.nacked)
          n.sub = ist_pkg::SUB_0;
        else if (r.tr)
        begin
          if (r.txb_v)
          begin
            n.sh = r.txbuf;
            n.txb_v = 1'b0;
            n.txf = 1'b1;
            n.sda_drv = ~r.txbuf[7];
            n.addr_ph = ist_pkg::PH_DATA;
            n.sub = ist_pkg::SUB_1;
          end
        end
        else
        begin
          n.addr_ph = ist_pkg::PH_DATA;
          n.sub = ist_pkg::SUB_1;
        end
      end
      default:
        n = CTL_RST;
    endcase

    if (!r.master && sc_start)
    begin
      n.st = ist_pkg::ST_XFER;
      n.master = 1'b0;
      n.bitcnt = 4'h0;
      n.addr_ph = ist_pkg::PH_FIRST;
      n.addressed = 1'b0;
      n.hold_low = 1'b0;
      n.sda_drv = 1'b0;
      n.bcnt = 8'h00;
    end
    if (!r.master && sc_stop)
    begin
      if (r.addressed)
        n.stpf = 1'b1;
      n.st = ist_pkg::ST_IDLE;
      n.addressed = 1'b0;
      n.ten_ok = 1'b0;
      n.hold_low = 1'b0;
      n.sda_drv = 1'b0;
    end
    if (!en)
      n = CTL_RST;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      r <= CTL_RST;
    else if (i_ce)
      r <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open drain: only ever pull low
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe = r.hold_low | gen_low;
  assign o_sda_oe = r.sda_drv;
  assign o_receive_buffer = r.rxbuf;
  assign o_receive_flag = r.rxf;
  assign o_transmit_flag = r.txf;
  assign o_start_match_flag = r.sttf;
  assign o_stop_detected_flag = r.stpf;
  assign o_nack_flag = r.nackf;
  assign o_transmit_direction_bit = r.tr;
  assign o_start_request = r.start_req;
  assign o_stop_request = r.stop_req;
  assign o_send_nack_request = r.nack_req;
  assign o_bus_busy = r.busy;
  assign o_master_active = r.master;
  assign o_scl_stretch = r.hold_low;

endmodule : ist_ctrl

`default_nettype wire

// ==== ist_pkg.sv ====
// How it works
// - Own address with write bit makes us slave receiver; master clocks.
// - Slave receiver clears direction bit, flags each byte, acks it.
// - Byte arrives while buffer unread: slave holds SCL low.
// - Buffer read during stall moves pending byte, acks, releases SCL.
// - Send-NACK request gives NACK in the next acknowledge slot.
// - Send-NACK during stall: release, NACK, overwrite buffer with pending.
// - STOP sets stop flag when addressed or master; repeated START returns to address reception.
// - Ten-bit slave: receiver after full address; re-read sets transmit.
// - Master needs I2C mode, synchronous and master select; multi-master.
// - Master waits for free bus, sends START, address, clears request.
// - Transmit flag at START and at each buffer to shifter move.
// - Empty transmit buffer at acknowledge: hold SCL low until written.
// - Stop request gives STOP after ack, even with no data sent.
// - Auto stop mode uses byte count to generate STOP.
// - Start request during a transfer gives repeated START.
// - Slave NACK sets flag, drops queued byte and pending requests.
// - Master receiver acks each byte and flags it until ended.
// - Unread buffer: master receiver holds last bit until read.
// - Stop as receiver: NACK then STOP, stop flag set.
package ist_pkg;

  localparam logic [15:0] BIT_DIV_DEF = 16'h0190;
  localparam logic [1:0] MODE_I2C = 2'h3;
  localparam logic [1:0] ASTP_BYTECNT = 2'h2;
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_POST = 4'h9;
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_FIRST = 2'h1;
  localparam logic [1:0] PH_SECOND = 2'h2;
  localparam logic [1:0] PH_REREAD = 2'h3;
  localparam logic [1:0] SUB_0 = 2'h0;
  localparam logic [1:0] SUB_1 = 2'h1;
  localparam logic [1:0] SUB_2 = 2'h2;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic LINE_RST = 1'b1;
  localparam int FCLR_RX = 0;
  localparam int FCLR_TX = 1;
  localparam int FCLR_STT = 2;
  localparam int FCLR_STP = 3;
  localparam int FCLR_NACK = 4;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_MSTA = 5'h02,
    ST_XFER = 5'h04,
    ST_HOLD = 5'h08,
    ST_MSTP = 5'h10
  } ist_state_t;

endpackage : ist_pkg

// ==== ist_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module ist_pin_sync (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop
);

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
  } ist_sync_t;

  ist_sync_t r;
  ist_sync_t n;

  always_comb
  begin
    n = r;
    n.scl1 = i_scl;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = i_sda;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      r <= {6{ist_pkg::LINE_RST}};
    else if (i_ce)
      r <= n;
  end

  // Edges and conditions only look past the first stage
  assign o_scl = r.scl2;
  assign o_sda = r.sda2;
  assign o_scl_rise = r.scl2 & ~r.scl3;
  assign o_scl_fall = ~r.scl2 & r.scl3;
  assign o_start = r.scl2 & r.scl3 & ~r.sda2 & r.sda3;
  assign o_stop = r.scl2 & r.scl3 & r.sda2 & ~r.sda3;

endmodule : ist_pin_sync

`default_nettype wire

// ==== ist_scl_gen.sv ====
`timescale 1ns/100ps
`default_nettype none

module ist_scl_gen #(
  parameter logic [15:0] BIT_DIV = ist_pkg::BIT_DIV_DEF
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_scl,
  output logic o_scl_low
);

  localparam logic [15:0] HALF_M1 = (BIT_DIV >> 1) - 16'h0001;

  typedef struct packed {
    logic low;
    logic [15:0] cnt;
  } ist_gen_t;

  ist_gen_t r;
  ist_gen_t n;

  always_comb
  begin
    n = r;
    if (!i_run)
    begin
      n.low = 1'b0;
      n.cnt = ist_pkg::TMR_RST;
    end
    else if (r.low || i_scl)
    begin
      // High phase counts only once the line is really high,
      // so a stretching slave slows us down
      if (r.cnt == HALF_M1)
      begin
        n.low = ~r.low;
        n.cnt = ist_pkg::TMR_RST;
      end
      else
        n.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      r <= '0;
    else if (i_ce)
      r <= n;
  end

  assign o_scl_low = r.low;

endmodule : ist_scl_gen

`default_nettype wire

// ==== ist_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

module ist_chk (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_swrst,
  input wire logic [1:0] i_serial_mode_select,
  input wire logic i_synchronous_select,
  input wire logic i_stop_request_set,
  input wire logic i_rx_rd,
  input wire logic [4:0] i_flag_clr,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic o_receive_flag,
  input wire logic o_nack_flag,
  input wire logic o_start_request,
  input wire logic o_stop_request,
  input wire logic o_bus_busy,
  input wire logic o_scl_stretch
);
  // Soft reset or a wrong mode holds the block like reset
  wire logic run = i_ce && !i_swrst && i_synchronous_select &&
    i_serial_mode_select == ist_pkg::MODE_I2C;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // Bus side and register properties
  // ----------------------------------------
  sequence ack_s;
    ##[1:16] o_sda_oe;
  endsequence
  mode_off_a: assert property (i_ce && !run |=>
    !o_scl_oe && !o_sda_oe && !o_start_request)
    else $error("line or request active while held off");
  ack_drive_a: assert property ($rose(o_receive_flag) |-> ack_s)
    else $error("no acknowledge after a received byte");
  stretch_oe_a: assert property (o_scl_stretch |-> o_scl_oe)
    else $error("stall flagged but clock line released");
  rx_release_a: assert property (o_scl_stretch && i_rx_rd && run
    |-> ##[1:4] !o_scl_stretch)
    else $error("stall kept after buffer read");
  start_clr_a: assert property ($fell(o_start_request) |-> o_bus_busy)
    else $error("start request cleared off a busy bus");
  stop_req_a: assert property (run && i_stop_request_set
    |=> o_stop_request)
    else $error("stop request not taken");
  nack_keep_a: assert property (run && o_nack_flag &&
    !i_flag_clr[ist_pkg::FCLR_NACK] |=> o_nack_flag)
    else $error("nack flag lost without clear");
  nack_drop_a: assert property ($rose(o_nack_flag)
    |-> ##[0:1] !o_start_request)
    else $error("start request survives a nack");
endmodule : ist_chk

`default_nettype wire

// ==== ist_peer.sv ====
`timescale 1ns/100ps
`default_nettype none

module ist_peer (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial {o_scl_oe, o_sda_oe} = 2'b00;
  // ----------------------------------------
  // Far side bus master
  // ----------------------------------------
  // the far master makes every clock
  task automatic start_cond();
    o_sda_oe = 1'b1;
    #100;
    o_scl_oe = 1'b1;
  endtask : start_cond
  // Waits out any stretch before sampling
  task automatic clk_bit(input logic v, output logic s);
    #25;
    o_sda_oe = ~v;
    #75;
    o_scl_oe = 1'b0;
    wait (i_scl === 1'b1);
    s = i_sda;
    #100;
    o_scl_oe = 1'b1;
  endtask : clk_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic stop_cond();
    #25;
    o_sda_oe = 1'b1;
    #75;
    o_scl_oe = 1'b0;
    #100;
    o_sda_oe = 1'b0;
    #100;
  endtask : stop_cond
endmodule : ist_peer

`default_nettype wire

// ==== ist_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam logic [9:0] own_addr = 10'h02a;
  localparam logic [9:0] tgt_addr = 10'h055;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_swrst = 1'b1;
  logic i_master_select = 1'b0;
  logic i_dir_wr = 1'b0;
  logic i_dir_val = 1'b0;
  logic i_start_request_set = 1'b0;
  logic i_stop_request_set = 1'b0;
  logic i_rx_rd = 1'b0;
  logic [4:0] i_flag_clr = 5'h00;
  logic [1:0] i_serial_mode_select = ist_pkg::MODE_I2C;
  logic i_synchronous_select = 1'b1;
  logic [9:0] i_own_address_reg = own_addr;
  logic [9:0] i_target_address_reg = tgt_addr;
  logic i_own_addr_ten_bit_sel = 1'b0;
  logic i_own_address_enable = 1'b1;
  logic i_general_call_enable = 1'b0;
  logic i_send_nack_set = 1'b0;
  logic i_tx_wr = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic [7:0] o_receive_buffer;
  logic o_scl_oe, o_sda_oe, o_receive_flag, o_transmit_flag;
  logic o_start_match_flag, o_stop_detected_flag, o_nack_flag;
  logic o_transmit_direction_bit, o_start_request, o_stop_request;
  logic o_send_nack_request, o_bus_busy, o_master_active, o_scl_stretch;
  logic p_scl_oe, p_sda_oe, ack;
  wire logic scl = ~(o_scl_oe | p_scl_oe);
  wire logic sda = ~(o_sda_oe | p_sda_oe);
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;

  ist_ctrl #(.BIT_DIV(16'h0010)) i_ist_ctrl (.*, .i_ce(1'b1),
    .i_scl(scl), .i_sda(sda), .o_scl_o(), .o_sda_o(),
    .i_multi_master_enable(1'b0), .i_target_addr_ten_bit_sel(1'b0),
    .i_auto_stop_select(2'h0), .i_byte_threshold(8'h00));
  ist_peer i_ist_peer (.i_scl(scl), .i_sda(sda), .o_scl_oe(p_scl_oe),
    .o_sda_oe(p_sda_oe));

  initial forever #12.5 i_clk = ~i_clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic slave_rx_test();
    int n;
    i_ist_peer.start_cond();
    i_ist_peer.send_byte({own_addr[6:0], 1'b0}, ack);
    check(8'(ack), 8'h01);
    check(8'(o_start_match_flag), 8'h01);
    check(8'(o_transmit_direction_bit), 8'h00);
    i_ist_peer.send_byte(8'ha5, ack);
    check(8'(ack), 8'h01);
    check(8'(o_receive_flag), 8'h01);
    check(o_receive_buffer, 8'ha5);
    fork
      i_ist_peer.send_byte(8'h3c, ack);
    join_none
    for (n = 0; n < 400 && o_scl_stretch !== 1'b1; n++) @(posedge i_clk);
    check(8'(o_scl_stretch), 8'h01);
    check(o_receive_buffer, 8'ha5);
    i_rx_rd <= 1'b1;
    @(posedge i_clk);
    i_rx_rd <= 1'b0;
    wait fork;
    check(8'(ack), 8'h01);
    check(o_receive_buffer, 8'h3c);
    @(posedge i_clk);
    i_send_nack_set <= 1'b1;
    @(posedge i_clk);
    i_send_nack_set <= 1'b0;
    @(negedge i_clk);
    check(8'(o_send_nack_request), 8'h01);
    // Buffer still full: the refused byte waits behind it
    i_ist_peer.send_byte(8'h5a, ack);
    check(8'(ack), 8'h00);
    check(8'(o_send_nack_request), 8'h00);
    @(posedge i_clk);
    i_rx_rd <= 1'b1;
    @(posedge i_clk);
    i_rx_rd <= 1'b0;
    @(negedge i_clk);
    check(o_receive_buffer, 8'h5a);
    i_ist_peer.stop_cond();
    repeat (8) @(posedge i_clk);
    check(8'(o_stop_detected_flag), 8'h01);
    $display("slave_rx_test ended");
  endtask : slave_rx_test

  task automatic master_nack_test();
    int n;
    i_flag_clr <= 5'h1f;
    i_master_select <= 1'b1;
    i_dir_wr <= 1'b1;
    i_dir_val <= 1'b1;
    i_tx_wr <= 1'b1;
    i_tx_data <= 8'h96;
    @(posedge i_clk);
    i_flag_clr <= 5'h00;
    i_dir_wr <= 1'b0;
    i_tx_wr <= 1'b0;
    i_start_request_set <= 1'b1;
    @(posedge i_clk);
    i_start_request_set <= 1'b0;
    @(negedge i_clk);
    check(8'(o_start_request), 8'h01);
    for (n = 0; n < 2000 && o_nack_flag !== 1'b1; n++) @(posedge i_clk);
    @(negedge i_clk);
    check(8'(o_nack_flag), 8'h01);
    check(8'(o_start_request), 8'h00);
    check(8'(o_transmit_flag), 8'h01);
    check(8'(o_master_active), 8'h01);
    @(posedge i_clk);
    i_stop_request_set <= 1'b1;
    @(posedge i_clk);
    i_stop_request_set <= 1'b0;
    for (n = 0; n < 2000 && o_stop_detected_flag !== 1'b1; n++)
      @(posedge i_clk);
    @(negedge i_clk);
    check(8'(o_stop_detected_flag), 8'h01);
    check(8'(o_stop_request), 8'h00);
    check(8'(o_bus_busy), 8'h00);
    check(8'(o_master_active), 8'h00);
    $display("master_nack_test ended");
  endtask : master_nack_test

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    i_swrst <= 1'b0;
    slave_rx_test();
    master_nack_test();
    stop_test();
  end
endmodule : testbench

bind ist_ctrl ist_chk i_ist_chk (.*);

`default_nettype wire
